// ==== hdl/i2c_timing_timeout_status.sv ====
// Summary of operation
// [RULE1] second address matches under 3-bit mask; 000 exact, n ignores n low, 111 all
// [RULE2] non-zero mask never acknowledges reserved 0000xxx and 1111xxx addresses
// [RULE3] software leaves second address and mask alone while it is enabled
// [RULE4] timing tick every prescaler+1 kernel clocks drives all SCL/SDA timing counters
// [RULE5] setup delay of setup+1 ticks before SCL rise, SCL held low
// [RULE6] hold delay of exactly hold ticks after SCL fall, SCL held low
// [RULE7] master drives SCL high high+1 ticks and low low+1 ticks
// [RULE8] cumulative own stretching over (B+1)*2048 clocks raises timeout
// [RULE9] software changes timeout B only with extended timeout disabled
// [RULE10] SCL low over (A+1)*2048, or idle high over (A+1)*4, raises timeout
// [RULE11] software changes idle select and timeout A only with detection disabled
// [RULE12] address match captures matched address and slave direction
// [RULE13] busy set on START, cleared on STOP or disable
// [RULE14] alert pin falling edge sets alert flag in host mode with detection
// [RULE15] timeout flag set by either timeout, cleared by clear bit or disable
// [RULE16] checksum mismatch sets its flag and forces a NACK
// [RULE17] slave without stretching flags lost or missing bytes as overrun
// [RULE18] arbitration loss sets its flag and drops back to slave
// [RULE19] misplaced START or STOP sets bus error flag
// [RULE20] byte count done sets reload-done or transfer-done, each with own clear
// [RULE21] stop, nack and address match flags set by events, cleared by clear bits
// [RULE22] rx-full set on load, cleared on read; tx-request set on ready, cleared on write
// [RULE23] tx-empty set when data empty, cleared on write, software set flushes
// [RULE24] writing one to a flag-clear bit clears that flag, zero does nothing
// [RULE25] clock timeout counter restarts when condition ends, extended one at START or STOP; both held clear while disabled
// [RULE26] disable returns flags to reset within one clock, tx-empty reads one
//
// Our own choice: register access over Avalon-MM.
module i2c_timing_timeout_status
  import i2c_tts_pkg::*;
#(
  parameter int TO_UNIT   = i2c_tts_pkg::TIMEOUT_UNIT,  // shorten for simulation
  parameter int IDLE_STEP = i2c_tts_pkg::IDLE_UNIT
) (
  input  wire logic        core_clk,          // kernel clock
  input  wire logic        reset_n,           // synchronous reset
  input  wire logic [7:0]  address,           // byte address
  input  wire logic        read,              // read request
  input  wire logic        write,             // write request
  input  wire logic [31:0] writedata,         // write data
  output logic      [31:0] readdata,          // read data
  output logic             waitrequest,       // stall
  input  wire logic        scl_in,            // SCL pin level
  input  wire logic        sda_in,            // SDA pin level
  input  wire logic        smb_alert_n_in,    // alert pin level
  output logic             scl_out,           // SCL drive value, always 0
  output logic             scl_oe,            // SCL pulled low
  output logic             sda_change,        // SDA may change now
  input  wire logic        master_active,     // engine owns the bus
  input  wire logic        addr_valid,        // address byte received
  input  wire logic [6:0]  rx_addr,           // received address bits
  input  wire logic        rx_dir,            // read bit of address
  input  wire logic        addr1_match,       // first address matched
  input  wire logic        nack_seen,         // NACK received
  input  wire logic        arb_lost,          // arbitration lost
  input  wire logic        pec_mismatch,      // checksum differs
  input  wire logic        bus_misplaced,     // START/STOP out of place
  input  wire logic        byte_count_done,   // byte count reached
  input  wire logic        data_lost,         // overrun or underrun
  input  wire logic        rx_loaded,         // byte into receive data
  input  wire logic        rx_read,           // receive data read
  input  wire logic        tx_ready,          // transmit data empty
  input  wire logic        tx_written,        // transmit data written
  input  wire logic        start_request,     // START requested
  input  wire logic        stop_request,      // STOP requested
  output logic             addr2_ack,         // second address hit
  output logic             force_nack,        // NACK regardless of request
  output logic             tx_flush,          // discard pending tx data
  output logic             periph_enable,     // block enable
  output logic             stretch_disable,   // slave stretching off
  output logic             reload_mode,       // reload after count
  output logic             auto_finish_mode,  // STOP after count
  output logic [7:0]       byte_count         // bytes per run
);
  import i2c_tts_pkg::*;

  typedef struct packed {
    logic       en;
    logic       host;
    logic       alert_en;
    logic       nostr;
    logic       reload;
    logic       auto_fin;
    logic [7:0] bcount;
    logic [31:0] timing;
    logic [31:0] tocfg;
    logic       sa_en;
    logic [2:0] sa_mask;
    logic [6:0] sa_val;
    logic [6:0] maddr;
    logic       dir;
    logic       busy;
    logic [13:0] flags;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [2:0] alr_sync;
    logic       scl_s;
    logic       sda_s;
    logic       alr_s;
    logic [3:0] psc_cnt;
    scl_state_t scl_st;
    logic [7:0] phase;
    logic [8:0] low_cnt;
    logic       oe;
    logic       sda_chg;
    logic [23:0] to_cnt;
    logic [23:0] ext_cnt;
    logic       waitreq;
    logic [31:0] rdata;
    logic       flush;
    logic       a2_ack;
    logic       fnack;
  } state_t;

  state_t st;
  state_t nx;

  function automatic logic addr2_hit(input logic [6:0] a, input logic [6:0] v,
                                     input logic [2:0] m);
    logic [6:0] care;
    logic       rsv;
    care = 7'h7F << m;
    rsv  = (a[6:3] == 4'h0) || (a[6:3] == 4'hF);
    return ((a & care) == (v & care)) && !((m != 3'h0) && rsv);
  endfunction

  logic        tick, scl_nx, sda_nx, alr_nx, start_det, stop_det, scl_fall;
  logic        wr_commit, a2_hit, to_cond, to_hit, ext_cond, ext_hit;
  logic [23:0] to_lim, ext_lim;
  logic [13:0] set_v, clr_v;
  logic [31:0] rd_v;

  always_comb begin
    nx = st;
    // pin synchronisers: a level counts once the last two stages agree
    nx.scl_sync = {st.scl_sync[1:0], scl_in};
    nx.sda_sync = {st.sda_sync[1:0], sda_in};
    nx.alr_sync = {st.alr_sync[1:0], smb_alert_n_in};
    scl_nx = (st.scl_sync[1] == st.scl_sync[2]) ? st.scl_sync[2] : st.scl_s;
    sda_nx = (st.sda_sync[1] == st.sda_sync[2]) ? st.sda_sync[2] : st.sda_s;
    alr_nx = (st.alr_sync[1] == st.alr_sync[2]) ? st.alr_sync[2] : st.alr_s;
    nx.scl_s = scl_nx;
    nx.sda_s = sda_nx;
    nx.alr_s = alr_nx;
    start_det = st.scl_s && scl_nx && st.sda_s && !sda_nx;
    stop_det  = st.scl_s && scl_nx && !st.sda_s && sda_nx;
    scl_fall  = st.scl_s && !scl_nx;

    tick = (st.psc_cnt == st.timing[PSC_LSB +: 4]);  // [RULE4]
    nx.psc_cnt = tick ? 4'h0 : st.psc_cnt + 4'h1;

    // bus slave: one wait cycle, access commits where waitrequest is low
    wr_commit = write && !st.waitreq;
    nx.waitreq = !((read || write) && st.waitreq);
    case (address)
      CTRL_OFS:    rd_v = {16'h0, st.bcount, 2'b00, st.auto_fin, st.reload,
                           st.nostr, st.alert_en, st.host, st.en};
      SADDR2_OFS:  rd_v = {16'h0, st.sa_en, 4'h0, st.sa_mask, st.sa_val, 1'b0};
      TIMING_OFS:  rd_v = st.timing;
      TIMEOUT_OFS: rd_v = st.tocfg;
      STATUS_OFS:  rd_v = {8'h0, st.maddr, st.dir, st.busy, 1'b0, st.flags};
      default:     rd_v = 32'h0;
    endcase
    nx.rdata = (read && st.waitreq) ? rd_v : 32'h0;
    nx.flush = 1'b0;
    clr_v = 14'h0;
    set_v = 14'h0;
    if (wr_commit) begin
      case (address)
        CTRL_OFS: begin
          nx.en       = writedata[EN_BIT];
          nx.host     = writedata[HOST_BIT];
          nx.alert_en = writedata[ALERT_BIT];
          nx.nostr    = writedata[NOSTR_BIT];
          nx.reload   = writedata[RELOAD_BIT];
          nx.auto_fin = writedata[AUTO_BIT];
          nx.bcount   = writedata[BCOUNT_LSB +: 8];
          if (writedata[BCOUNT_LSB +: 8] != 8'h00) clr_v[F_RELOAD] = 1'b1;  // [RULE20]
        end
        SADDR2_OFS: begin
          nx.sa_en   = writedata[SA_EN_BIT];
          nx.sa_mask = writedata[SA_MASK_LSB +: 3];
          nx.sa_val  = writedata[SA_VAL_LSB +: 7];
        end
        TIMING_OFS:  nx.timing = writedata & TIMING_MASK;
        TIMEOUT_OFS: nx.tocfg  = writedata & TIMEOUT_MASK;
        STATUS_OFS: begin
          if (writedata[F_TXREQ] && st.nostr) set_v[F_TXREQ] = 1'b1;  // [RULE22]
          if (writedata[F_TXEMPTY]) begin
            set_v[F_TXEMPTY] = 1'b1;  // [RULE23]
            nx.flush = 1'b1;
          end
        end
        FCLR_OFS: clr_v = clr_v | (writedata[13:0] & FCLR_MASK);  // [RULE24]
        default: ;
      endcase
    end

    // second address compare and capture
    a2_hit = st.sa_en && addr2_hit(rx_addr, st.sa_val, st.sa_mask);  // [RULE1] [RULE2]
    nx.a2_ack = addr_valid && a2_hit && st.en;
    if (addr_valid && (a2_hit || addr1_match)) begin
      nx.maddr = rx_addr;  // [RULE12]
      nx.dir   = rx_dir;
      set_v[F_ADDR] = 1'b1;  // [RULE21]
    end

    // clock timeout: SCL low, or idle bus high when idle select is set
    if (st.tocfg[IDLE_SEL_BIT]) begin
      to_cond = st.scl_s && st.sda_s && !st.busy;
      to_lim  = 24'(({12'h0, st.tocfg[TOA_LSB +: 12]} + 24'h1) * 24'(IDLE_STEP));
    end else begin
      to_cond = !st.scl_s;
      to_lim  = 24'(({12'h0, st.tocfg[TOA_LSB +: 12]} + 24'h1) * 24'(TO_UNIT));
    end  // [RULE10]
    to_cond = to_cond && st.tocfg[TO_EN_BIT] && st.en;
    to_hit  = to_cond && (st.to_cnt == to_lim - 24'h1);
    nx.to_cnt = !to_cond ? 24'h0 : (st.to_cnt == to_lim ? st.to_cnt
                                                        : st.to_cnt + 24'h1);  // [RULE25]
    // extended timeout: our own SCL stretching, summed from START to STOP
    ext_lim  = 24'(({12'h0, st.tocfg[TOB_LSB +: 12]} + 24'h1) * 24'(TO_UNIT));
    ext_cond = st.oe && st.tocfg[EXT_EN_BIT] && st.en;
    ext_hit  = ext_cond && (st.ext_cnt == ext_lim - 24'h1);  // [RULE8]
    if (!st.tocfg[EXT_EN_BIT] || !st.en || start_det || stop_det)
      nx.ext_cnt = 24'h0;  // [RULE25]
    else if (ext_cond && st.ext_cnt != ext_lim)
      nx.ext_cnt = st.ext_cnt + 24'h1;

    // event sources for sticky flags
    if (to_hit || ext_hit) set_v[F_TIMEOUT] = 1'b1;  // [RULE15]
    if (st.host && st.alert_en && st.alr_s && !alr_nx) set_v[F_ALERT] = 1'b1;  // [RULE14]
    if (pec_mismatch) set_v[F_PEC] = 1'b1;  // [RULE16]
    if (data_lost && st.nostr && !master_active) set_v[F_OVR] = 1'b1;  // [RULE17]
    if (arb_lost) set_v[F_ARB] = 1'b1;  // [RULE18]
    if (bus_misplaced) set_v[F_BUS_ERROR_FLAG] = 1'b1;  // [RULE19]
    if (byte_count_done && st.reload) set_v[F_RELOAD] = 1'b1;  // [RULE20]
    if (byte_count_done && !st.reload && !st.auto_fin) set_v[F_XFER] = 1'b1;
    if (start_request || stop_request) clr_v[F_XFER] = 1'b1;
    if (stop_det) set_v[F_STOP] = 1'b1;  // [RULE21]
    if (nack_seen) set_v[F_NACK] = 1'b1;
    if (rx_loaded) set_v[F_RXFULL] = 1'b1;  // [RULE22]
    if (rx_read) clr_v[F_RXFULL] = 1'b1;
    if (tx_ready) set_v[F_TXREQ] = 1'b1;
    if (tx_ready) set_v[F_TXEMPTY] = 1'b1;  // [RULE23]
    if (tx_written) clr_v[F_TXREQ] = 1'b1;
    if (tx_written) clr_v[F_TXEMPTY] = 1'b1;
    // a set arriving with its clear wins, so no event is lost
    nx.flags = set_v | (st.flags & ~clr_v);
    nx.busy  = start_det || (st.busy && !stop_det);  // [RULE13]
    nx.fnack = pec_mismatch && st.en;  // [RULE16]

    // SCL timing engine
    nx.sda_chg = 1'b0;
    if (tick && st.low_cnt <= {1'b0, st.timing[LOW_LSB +: 8]})
      nx.low_cnt = st.low_cnt + 9'h1;
    case (st.scl_st)
      SCL_IDLE: begin
        nx.oe = 1'b0;
        if (master_active) begin
          nx.scl_st  = SCL_HOLD;
          nx.oe      = 1'b1;
          nx.phase   = {4'h0, st.timing[HOLD_LSB +: 4]};
          nx.low_cnt = 9'h0;
        end else if (scl_fall) begin
          nx.scl_st = SCL_HOLD;
          nx.oe     = !st.nostr;  // [RULE6]
          nx.phase  = {4'h0, st.timing[HOLD_LSB +: 4]};
        end
      end
      SCL_HOLD: begin
        if (st.phase == 8'h00) begin
          nx.sda_chg = 1'b1;  // [RULE6]
          nx.scl_st  = SCL_SETUP;
          nx.phase   = {4'h0, st.timing[SETUP_LSB +: 4]};
        end else if (tick) begin
          nx.phase = st.phase - 8'h01;
        end
      end
      SCL_SETUP: begin
        if (tick && st.phase == 8'h00) begin
          if (master_active) begin
            nx.scl_st = SCL_LOW;  // [RULE5]
          end else begin
            nx.scl_st = SCL_IDLE;
            nx.oe     = 1'b0;
          end
        end else if (tick) begin
          nx.phase = st.phase - 8'h01;
        end
      end
      SCL_LOW: begin
        if (st.low_cnt > {1'b0, st.timing[LOW_LSB +: 8]}) begin
          nx.scl_st = SCL_HIGH;  // [RULE7]
          nx.oe     = 1'b0;
          nx.phase  = 8'h00;
        end
      end
      SCL_HIGH: begin
        if (!master_active) begin
          nx.scl_st = SCL_IDLE;
        end else if (tick && st.scl_s) begin
          if (st.phase == st.timing[HIGH_LSB +: 8]) begin
            nx.scl_st  = SCL_HOLD;  // [RULE7]
            nx.oe      = 1'b1;
            nx.phase   = {4'h0, st.timing[HOLD_LSB +: 4]};
            nx.low_cnt = 9'h0;
          end else begin
            nx.phase = st.phase + 8'h01;
          end
        end
      end
      default: begin
        nx.scl_st = SCL_IDLE;
        nx.oe     = 1'b0;
      end
    endcase
    // losing arbitration hands the clock back at once
    if (arb_lost && master_active) begin
      nx.scl_st = SCL_IDLE;  // [RULE18]
      nx.oe     = 1'b0;
    end

    if (!st.en) begin
      nx.flags   = STATUS_RST[13:0];  // [RULE26]
      nx.busy    = 1'b0;
      nx.scl_st  = SCL_IDLE;
      nx.oe      = 1'b0;
      nx.sda_chg = 1'b0;
      nx.a2_ack  = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st         <= '0;
      st.timing  <= TIMING_RST;
      st.tocfg   <= TIMEOUT_RST;
      st.flags   <= STATUS_RST[13:0];
      st.waitreq <= 1'b1;
      st.scl_st  <= SCL_IDLE;
    end else begin
      st <= nx;
    end
  end

  assign readdata         = st.rdata;
  assign waitrequest      = st.waitreq;
  assign scl_out          = 1'b0;
  assign scl_oe           = st.oe;
  assign sda_change       = st.sda_chg;
  assign addr2_ack        = st.a2_ack;
  assign force_nack       = st.fnack;
  assign tx_flush         = st.flush;
  assign periph_enable    = st.en;
  assign stretch_disable  = st.nostr;
  assign reload_mode      = st.reload;
  assign auto_finish_mode = st.auto_fin;
  assign byte_count       = st.bcount;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_addr2_exact: assert property ( // [RULE1]
    addr_valid && st.en && st.sa_en && st.sa_mask == 3'h0 && rx_addr == st.sa_val
    |=> addr2_ack && st.maddr == $past(rx_addr) && st.flags[F_ADDR])
    else $error("second address exact match missed");
  chk_addr2_reserved: assert property ( // [RULE2]
    addr_valid && st.sa_mask != 3'h0 && (rx_addr[6:3] == 4'h0 || rx_addr[6:3] == 4'hF)
    |=> !addr2_ack)
    else $error("reserved address acknowledged");
  chk_tick_spacing: assert property ( // [RULE4]
    tick && st.timing[PSC_LSB +: 4] != 4'h0 && !(wr_commit && address == TIMING_OFS)
    |=> !tick)
    else $error("timing tick too close");
  chk_setup_stretch: assert property ( // [RULE5]
    st.scl_st == SCL_SETUP && master_active && st.en |-> scl_oe)
    else $error("scl released during setup");
  chk_hold_zero: assert property ( // [RULE6]
    st.en && st.scl_st == SCL_HOLD && st.phase == 8'h00 && !arb_lost
    |=> sda_change && st.scl_st == SCL_SETUP)
    else $error("hold end without sda change");
  chk_master_high: assert property ( // [RULE7]
    st.scl_st == SCL_HIGH |-> !scl_oe)
    else $error("scl driven during high phase");
  chk_timeout_flag: assert property ( // [RULE15]
    st.en && (to_hit || ext_hit) |=> st.flags[F_TIMEOUT])
    else $error("timeout not flagged");
  chk_busy_start: assert property ( // [RULE13]
    st.en && start_det |=> st.busy ##1 (st.busy || $past(stop_det) || !$past(st.en)))
    else $error("busy not set on start");
  chk_set_wins: assert property ( // [RULE24]
    st.en && nack_seen && wr_commit && address == FCLR_OFS && writedata[F_NACK]
    |=> st.flags[F_NACK])
    else $error("nack event lost to clear");
  chk_disable_flags: assert property ( // [RULE26]
    !st.en |=> st.flags == STATUS_RST[13:0] && !st.busy && !scl_oe)
    else $error("flags not reset on disable");
  chk_pec_nack: assert property ( // [RULE16]
    st.en && pec_mismatch |=> force_nack && st.flags[F_PEC])
    else $error("checksum error without nack");
  chk_overrun_set: assert property ( // [RULE17]
    st.en && data_lost && st.nostr && !master_active |=> st.flags[F_OVR])
    else $error("overrun not flagged");

  cov_master_cycle: cover property (st.scl_st == SCL_LOW ##[1:600] st.scl_st == SCL_HIGH);
  cov_timeout_hit: cover property (to_hit);
  cov_addr2_masked: cover property (addr2_ack && st.sa_mask == 3'h7);
  cov_bus_write: cover property (wr_commit && address == FCLR_OFS);

endmodule

// ==== hdl/i2c_tts_pkg.sv ====
package i2c_tts_pkg;

  // byte offsets on the register bus
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] SADDR2_OFS  = 8'h0C;
  localparam logic [7:0] TIMING_OFS  = 8'h10;
  localparam logic [7:0] TIMEOUT_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS  = 8'h18;
  localparam logic [7:0] FCLR_OFS    = 8'h1C;

  // values after reset and writable-bit masks
  localparam logic [31:0] TIMING_RST   = 32'h0000_0000;
  localparam logic [31:0] TIMEOUT_RST  = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST   = 32'h0000_0001;
  localparam logic [31:0] TIMING_MASK  = 32'hF0FF_FFFF;
  localparam logic [31:0] TIMEOUT_MASK = 32'h8FFF_9FFF;
  localparam logic [13:0] FCLR_MASK    = 14'h3F38;

  // timing_config fields
  localparam int PSC_LSB   = 28;
  localparam int SETUP_LSB = 20;
  localparam int HOLD_LSB  = 16;
  localparam int HIGH_LSB  = 8;
  localparam int LOW_LSB   = 0;

  // timeout_config fields
  localparam int EXT_EN_BIT   = 31;
  localparam int TOB_LSB      = 16;
  localparam int TO_EN_BIT    = 15;
  localparam int IDLE_SEL_BIT = 12;
  localparam int TOA_LSB      = 0;
  localparam int TIMEOUT_UNIT = 2048;  // kernel clocks per timeout step
  localparam int IDLE_UNIT    = 4;     // kernel clocks per idle step

  // second_slave_address fields
  localparam int SA_EN_BIT   = 15;
  localparam int SA_MASK_LSB = 8;
  localparam int SA_VAL_LSB  = 1;

  // block_control fields
  localparam int EN_BIT      = 0;
  localparam int HOST_BIT    = 1;
  localparam int ALERT_BIT   = 2;
  localparam int NOSTR_BIT   = 3;
  localparam int RELOAD_BIT  = 4;
  localparam int AUTO_BIT    = 5;
  localparam int BCOUNT_LSB  = 8;

  // status_flags bit positions
  localparam int ST_DIR_BIT  = 16;
  localparam int ST_ADDR_LSB = 17;
  localparam int ST_BUSY     = 15;
  localparam int F_ALERT     = 13;
  localparam int F_TIMEOUT   = 12;
  localparam int F_PEC       = 11;
  localparam int F_OVR       = 10;
  localparam int F_ARB       = 9;
  localparam int F_BUS_ERROR_FLAG      = 8;
  localparam int F_RELOAD    = 7;
  localparam int F_XFER      = 6;
  localparam int F_STOP      = 5;
  localparam int F_NACK      = 4;
  localparam int F_ADDR      = 3;
  localparam int F_RXFULL    = 2;
  localparam int F_TXREQ     = 1;
  localparam int F_TXEMPTY   = 0;

  typedef enum logic [4:0] {
    SCL_IDLE  = 5'b00001,
    SCL_HOLD  = 5'b00010,
    SCL_SETUP = 5'b00100,
    SCL_LOW   = 5'b01000,
    SCL_HIGH  = 5'b10000
  } scl_state_t;

endpackage

// ==== testbench/i2c_bus_partner.sv ====
module i2c_bus_partner (
  input  wire logic dut_scl_oe,   // design pulls SCL low
  input  wire logic hold_scl,     // far side stretches SCL low
  input  wire logic hold_sda,     // far side pulls SDA low
  input  wire logic hold_alert,   // far side asserts alert
  output logic      scl_line,     // wired SCL level
  output logic      sda_line,     // wired SDA level
  output logic      alert_n_line  // wired alert level
);
  timeunit 1ns;
  timeprecision 1ns;
  // open drain with pull-ups: any party pulling low wins
  assign scl_line     = !(dut_scl_oe || hold_scl);
  assign sda_line     = !hold_sda;
  assign alert_n_line = !hold_alert;
endmodule

// ==== testbench/i2c_timing_timeout_status_tb_top.sv ====
module i2c_timing_timeout_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import i2c_tts_pkg::*;
  localparam int TOU = 8;  // short timeout unit keeps the run brief
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic [6:0]  rx_addr = 7'h00;
  logic [12:0] ev = 13'h0;
  logic        hs = 1'b0, hd = 1'b0, ha = 1'b0;
  logic        waitrequest, scl, sda, aln, scl_oe, addr2_ack, force_nack, pe;
  int          err_count = 0;
  int          comparisons = 0;
  int          evi [8] = '{0, 1, 2, 3, 5, 4, 6, 8};
  int          fb [8] = '{4, 9, 11, 8, 10, 6, 2, 1};
  int          cl [8] = '{-1, -1, -1, -1, -1, 10, 7, 9};
  logic [2:0]  am [6] = '{3'h0, 3'h0, 3'h3, 3'h7, 3'h7, 3'h7};
  logic [6:0]  av [6] = '{7'h42, 7'h42, 7'h42, 7'h00, 7'h00, 7'h00};
  logic [6:0]  aa [6] = '{7'h42, 7'h43, 7'h45, 7'h03, 7'h55, 7'h7A};
  logic        ae [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #10 core_clk = ~core_clk;

  i2c_bus_partner far (.dut_scl_oe(scl_oe), .hold_scl(hs), .hold_sda(hd), .hold_alert(ha),
    .scl_line(scl), .sda_line(sda), .alert_n_line(aln));

  i2c_timing_timeout_status #(.TO_UNIT(TOU), .IDLE_STEP(4)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .scl_in(scl), .sda_in(sda), .smb_alert_n_in(aln), .scl_out(), .scl_oe(scl_oe),
    .sda_change(), .master_active(1'b0), .addr_valid(ev[12]), .rx_addr(rx_addr),
    .rx_dir(1'b1), .addr1_match(1'b0), .nack_seen(ev[0]), .arb_lost(ev[1]),
    .pec_mismatch(ev[2]), .bus_misplaced(ev[3]), .byte_count_done(ev[4]),
    .data_lost(ev[5]), .rx_loaded(ev[6]), .rx_read(ev[7]), .tx_ready(ev[8]),
    .tx_written(ev[9]), .start_request(ev[10]), .stop_request(ev[11]),
    .addr2_ack(addr2_ack), .force_nack(force_nack), .tx_flush(), .periph_enable(pe),
    .stretch_disable(), .reload_mode(), .auto_finish_mode(), .byte_count());

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
    #1;
  endtask

  task automatic addr_try(input logic [2:0] m, input logic [6:0] v, input logic [6:0] a,
                          input logic e);
    bus(1'b1, SADDR2_OFS, {21'h0, m, v, 1'b0});
    bus(1'b1, SADDR2_OFS, {16'h0, 1'b1, 4'h0, m, v, 1'b0});
    rx_addr <= a;
    pulse(12);
    chk("addr2_ack", {31'h0, e}, {31'h0, addr2_ack});
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("address flag", {31'h0, e}, {31'h0, rd[F_ADDR]});
    if (e) chk("matched address", {a, 1'b1}, rd[23:16]);
    bus(1'b1, FCLR_OFS, 32'h8);
    bus(1'b1, SADDR2_OFS, 32'h0);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus(1'b0, TIMING_OFS, 32'h0);
    chk("timing reset", TIMING_RST, rd);
    bus(1'b0, TIMEOUT_OFS, 32'h0);
    chk("timeout reset", TIMEOUT_RST, rd);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("status reset", STATUS_RST, rd);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, TIMING_OFS, 32'hFFFF_FFFF);
    bus(1'b0, TIMING_OFS, 32'h0);
    chk("timing fields", TIMING_MASK, rd);
    bus(1'b1, TIMING_OFS, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h0000_000F);
    ha <= 1'b1;
    repeat (6) @(posedge core_clk);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("alert set", 32'h1, rd[F_ALERT]);
    ha <= 1'b0;
    bus(1'b1, FCLR_OFS, 32'h2000);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("alert clear", 32'h0, rd[F_ALERT]);
    hd <= 1'b1;
    repeat (6) @(posedge core_clk);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("busy on start", 32'h1, rd[ST_BUSY]);
    hd <= 1'b0;
    repeat (6) @(posedge core_clk);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("busy after stop", 32'h0, rd[ST_BUSY]);
    chk("stop flag", 32'h1, rd[F_STOP]);
    for (int i = 0; i < 6; i++) addr_try(am[i], av[i], aa[i], ae[i]);
    for (int i = 0; i < 8; i++) begin
      pulse(evi[i]);
      if (evi[i] == 2) chk("force_nack", 32'h1, force_nack);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("flag set", 32'h1, rd[fb[i]]);
      if (cl[i] < 0) bus(1'b1, FCLR_OFS, 32'h1 << fb[i]);
      else pulse(cl[i]);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("flag clear", 32'h0, rd[fb[i]]);
    end
    // nack event lands on the very edge its clear commits
    fork
      bus(1'b1, FCLR_OFS, 32'h10);
      begin
        @(posedge core_clk);
        pulse(0);
      end
    join
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("nack set beats clear", 32'h1, rd[F_NACK]);
    bus(1'b1, FCLR_OFS, 32'h10);
    bus(1'b1, STATUS_OFS, 32'h2);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("tx request by software", 32'h1, rd[F_TXREQ]);
    bus(1'b1, CTRL_OFS, 32'h0000_001F);
    pulse(4);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("reload done", 32'h1, rd[F_RELOAD]);
    bus(1'b1, CTRL_OFS, 32'h0000_010F);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("reload done clear", 32'h0, rd[F_RELOAD]);
    bus(1'b1, TIMEOUT_OFS, 32'h0000_0001);
    bus(1'b1, TIMEOUT_OFS, 32'h0000_8001);
    // two short lows with a gap must not add up
    hs <= 1'b1;
    repeat (2 * TOU - 4) @(posedge core_clk);
    hs <= 1'b0;
    repeat (4) @(posedge core_clk);
    hs <= 1'b1;
    repeat (2 * TOU - 4) @(posedge core_clk);
    hs <= 1'b0;
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("no timeout", 32'h0, rd[F_TIMEOUT]);
    hs <= 1'b1;
    repeat (2 * TOU + 8) @(posedge core_clk);
    hs <= 1'b0;
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("clock timeout", 32'h1, rd[F_TIMEOUT]);
    bus(1'b1, CTRL_OFS, 32'h0);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk("status after disable", {16'h0, STATUS_RST[15:0]}, {16'h0, rd[15:0]});
    final_report();
  end

  initial begin
    #200000;
    err_count++;
    final_report();
  end
endmodule
